// [design/cmoc_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cmoc_consts.svh"

module cmoc_top (
  input  wire logic       CLK,                   // I/O clock or async oscillator
  input  wire logic       RESET_N,               // Async reset
  input  wire logic [7:0] BUS_ADDR,              // CPU register address
  input  wire logic       BUS_IO_SPACE,          // Address is in I/O space
  input  wire logic       BUS_WRITE,             // Write strobe
  input  wire logic       BUS_READ,              // Read strobe
  input  wire logic [7:0] BUS_WDATA,             // Write data
  output logic      [7:0] BUS_RDATA,             // Read data
  input  wire logic       TICK_EN,               // Timer tick enable
  input  wire logic [7:0] CHAN_A_COMPARE_VALUE,  // Compare value A
  input  wire logic [7:0] CHAN_B_COMPARE_VALUE,  // Compare value B
  input  wire logic       MATCH_A,               // Compare match A
  input  wire logic       MATCH_B,               // Compare match B
  input  wire logic       AT_TOP,                // Counter at top
  input  wire logic       AT_BOTTOM,             // Counter at bottom
  input  wire logic       COUNT_UP,              // Counter counting up
  input  wire logic       WAVEFORM_MODE_HI_BIT,  // High mode bit from control B
  input  wire logic       FORCE_A,               // Forced compare strobe A
  input  wire logic       FORCE_B,               // Forced compare strobe B
  input  wire logic       DIR_A,                 // Direction bit of A pin
  input  wire logic       DIR_B,                 // Direction bit of B pin
  input  wire logic       PORT_A,                // Port data of A pin
  input  wire logic       PORT_B,                // Port data of B pin
  output logic      [2:0] WAVEFORM_MODE_SEL,     // Full mode to counter core
  output logic            CHAN_A_WAVE_OUT,       // Waveform state A
  output logic            CHAN_B_WAVE_OUT,       // Waveform state B
  output logic            CHAN_A_CONNECTED,      // A pin owned by waveform
  output logic            CHAN_B_CONNECTED,      // B pin owned by waveform
  output logic            PIN_A_OUT,             // A pin level
  output logic            PIN_A_OE,              // A pin driver enable
  output logic            PIN_B_OUT,             // B pin level
  output logic            PIN_B_OE               // B pin driver enable
);

  // I/O space address of the control register
  // Derived from the data address, so the two spaces cannot disagree
  localparam logic [7:0] ADDR_IO = 8'(`CMOC_ADDR_DATA - `CMOC_IO_DISTANCE);

  // Register state
  cmoc_pkg::cmoc_ctrl_t   ctrl;         // Control register
  cmoc_pkg::cmoc_ctrl_t   next_ctrl;    // Next control value
  logic [7:0]             rdata;        // Read data register
  logic [7:0]             next_rdata;   // Next read data
  logic                   hit;          // Address selects the register

  // Mode decode and counter events
  logic [2:0]             mode;         // Combined mode bits
  cmoc_pkg::cmoc_class_t  mode_class;   // Decoded mode class
  logic [7:0]             top_value;    // Current top
  cmoc_pkg::cmoc_events_t ev;           // Counter events

  // Channel ownership and waveform levels
  logic                   conn_a;       // A field nonzero
  logic                   conn_b;       // B field nonzero
  logic                   wave_a;       // Channel A level
  logic                   wave_b;       // Channel B level
  logic                   force_a_q;    // Force A allowed
  logic                   force_b_q;    // Force B allowed

  // Pin output stage
  logic [5:0]             pins;         // Registered pin outputs
  logic [5:0]             next_pins;    // Next pin outputs

  // Decode mode bits into a class
  function automatic cmoc_pkg::cmoc_class_t decode_class(input logic [2:0] m);
    case (m)
      `CMOC_WGM_NORMAL, `CMOC_WGM_CTC:     decode_class = cmoc_pkg::CMOC_NON_PWM;
      `CMOC_WGM_FAST_FF, `CMOC_WGM_FAST_OCA: decode_class = cmoc_pkg::CMOC_FAST_PWM;
      `CMOC_WGM_PC_FF, `CMOC_WGM_PC_OCA:   decode_class = cmoc_pkg::CMOC_PHASE_PWM;
      // Reserved codes land in a class where both channels hold
      default:                             decode_class = cmoc_pkg::CMOC_RESERVED;
    endcase
  endfunction

  // Address compare for either address space
  function automatic logic addr_hit(input logic [7:0] a, input logic io);
    addr_hit = io ? (a == ADDR_IO) : (a == `CMOC_ADDR_DATA);
  endfunction

  // Register access decode and next values
  always_comb begin
    // Both address spaces decode to the one register
    hit        = addr_hit(BUS_ADDR, BUS_IO_SPACE);
    // Hold unless accessed
    next_ctrl  = ctrl;
    next_rdata = rdata;
    if (hit && BUS_WRITE) begin
      // Reserved bits stay zero
      next_ctrl = cmoc_pkg::cmoc_ctrl_t'(BUS_WDATA & `CMOC_WRITE_MASK);
    end
    // Same-cycle read returns the value before the write
    if (hit && BUS_READ) begin
      next_rdata = ctrl;
    end else if (BUS_READ) begin
      // Unmapped address reads zero
      next_rdata = `CMOC_RESET_VALUE;
    end
  end

  // Register file
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // All implemented bits clear
      ctrl  <= cmoc_pkg::cmoc_ctrl_t'(`CMOC_RESET_VALUE);
      rdata <= `CMOC_RESET_VALUE;
    end else begin
      ctrl  <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // Mode, top and event bundling
  always_comb begin
    mode       = {WAVEFORM_MODE_HI_BIT, ctrl.wgm};
    mode_class = decode_class(mode);
    // Top from compare A only in the two compare-top PWM modes
    case (mode)
      `CMOC_WGM_PC_OCA, `CMOC_WGM_FAST_OCA: begin
        top_value = CHAN_A_COMPARE_VALUE;
      end
      default: begin
        // Fixed top, also where top plays no part
        top_value = `CMOC_MAX_COUNT;
      end
    endcase
    // Tick gates every event; an async instance clocks CLK from its oscillator
    // Events pass through as the counter core presents them
    ev.tick      = TICK_EN;    // Enable on CLK, not a clock
    ev.at_top    = AT_TOP;
    ev.at_bottom = AT_BOTTOM;
    ev.count_up  = COUNT_UP;
    // Forced compare acts in non-PWM modes only
    // A strobe in a PWM mode is dropped, not stored
    force_a_q    = FORCE_A && (mode_class == cmoc_pkg::CMOC_NON_PWM);
    force_b_q    = FORCE_B && (mode_class == cmoc_pkg::CMOC_NON_PWM);
    conn_a       = |ctrl.com_a;
    conn_b       = |ctrl.com_b;
  end

  // Channel A waveform unit, toggle allowed in PWM
  // Compare at top: match ignored, level applied at bottom in fast PWM, at top in phase PWM
  cmoc_wave_chan #(
    .TOGGLE_IN_PWM  (1'b1),
    .SPECIAL_AT_TOP (1'b0)
  ) u_chan_a (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .mode_class (mode_class),
    .com        (ctrl.com_a),
    .mode_hi    (WAVEFORM_MODE_HI_BIT),
    .ev         (ev),
    .match      (MATCH_A),
    .force_cmp  (force_a_q),
    .cmp_is_top (CHAN_A_COMPARE_VALUE == top_value),
    .wave       (wave_a)
  );

  // Channel B waveform unit, toggle reserved in PWM
  // Compare at top: match ignored, level applied at top instead
  cmoc_wave_chan #(
    .TOGGLE_IN_PWM  (1'b0),
    .SPECIAL_AT_TOP (1'b1)
  ) u_chan_b (
    .clk        (CLK),
    .reset_n    (RESET_N),
    .mode_class (mode_class),
    .com        (ctrl.com_b),
    .mode_hi    (WAVEFORM_MODE_HI_BIT),
    .ev         (ev),
    .match      (MATCH_B),
    .force_cmp  (force_b_q),
    .cmp_is_top (CHAN_B_COMPARE_VALUE == top_value),
    .wave       (wave_b)
  );

  // Pin multiplexing
  always_comb begin
    // Slots: 0/1 A level and enable, 2/3 B, 4/5 ownership
    next_pins    = '0;
    // Waveform overrides port data when connected
    next_pins[0] = conn_a ? wave_a : PORT_A;
    // Driver follows the direction bit only
    next_pins[1] = DIR_A;
    // Channel B slots
    next_pins[2] = conn_b ? wave_b : PORT_B;
    next_pins[3] = DIR_B;
    // Ownership status
    next_pins[4] = conn_a;
    next_pins[5] = conn_b;
  end

  // Pin registers
  // Registered so a register write never glitches a pin
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  // Outputs
  // Register bus
  assign BUS_RDATA         = rdata;
  // Counter core
  assign WAVEFORM_MODE_SEL = mode;
  // Waveform states, live even while disconnected
  assign CHAN_A_WAVE_OUT   = wave_a;
  assign CHAN_B_WAVE_OUT   = wave_b;
  // Pin levels and driver enables
  assign PIN_A_OUT         = pins[0];
  assign PIN_A_OE          = pins[1];
  assign PIN_B_OUT         = pins[2];
  assign PIN_B_OE          = pins[3];
  // Pin ownership status
  assign CHAN_A_CONNECTED  = pins[4];
  assign CHAN_B_CONNECTED  = pins[5];

endmodule

`default_nettype wire

// [design/cmoc_consts.svh]
// Notes on behaviour
// - Tick is a clock enable, single clock.
// - Async instance clocks CLK from oscillator.
// - Nonzero A mode field takes the A pin.
// - Non-PWM A: off, toggle, clear, set.
// - Fast A 01: off, toggles when hi bit.
// - Fast A 10/11: match level, bottom opposite.
// - Fast A compare at top: bottom only.
// - Phase A: up-match and down-match opposite levels.
// - Phase A compare at top: act at top.
// - Nonzero B mode field takes the B pin.
// - Non-PWM B: off, toggle, clear, set.
// - Fast B: 01 reserved, 10/11 as A.
// - Fast B compare at top: act at top.
// - Phase B: 01 reserved, 10/11 up/down opposite.
// - Register at 0x44 data, 0x24 I/O.
// - Three mode bits select waveform mode.
`ifndef CMOC_CONSTS_SVH
`define CMOC_CONSTS_SVH

// Register addressing
`define CMOC_ADDR_DATA    8'h44
`define CMOC_IO_DISTANCE  8'h20
`define CMOC_RESET_VALUE  8'h00
`define CMOC_WRITE_MASK   8'hF3

// Field positions
`define CMOC_COM_A_HI     7
`define CMOC_COM_A_LO     6
`define CMOC_COM_B_HI     5
`define CMOC_COM_B_LO     4
`define CMOC_WGM_HI       1
`define CMOC_WGM_LO       0

// Waveform mode codes
`define CMOC_WGM_NORMAL   3'h0
`define CMOC_WGM_PC_FF    3'h1
`define CMOC_WGM_CTC      3'h2
`define CMOC_WGM_FAST_FF  3'h3
`define CMOC_WGM_PC_OCA   3'h5
`define CMOC_WGM_FAST_OCA 3'h7

// Output mode field codes
`define CMOC_COM_OFF      2'h0
`define CMOC_COM_TOGGLE   2'h1
`define CMOC_COM_CLEAR    2'h2
`define CMOC_COM_SET      2'h3

// Count limits
`define CMOC_MAX_COUNT    8'hFF

`endif

// [design/cmoc_pkg.sv]
package cmoc_pkg;

  // Waveform mode class derived from the three mode bits
  typedef enum logic [1:0] {
    CMOC_NON_PWM,
    CMOC_FAST_PWM,
    CMOC_PHASE_PWM,
    CMOC_RESERVED
  } cmoc_class_t;

  // Control register layout
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] unused;
    logic [1:0] wgm;
  } cmoc_ctrl_t;

  // Counter core events, all sampled on CLK
  typedef struct packed {
    logic tick;
    logic at_top;
    logic at_bottom;
    logic count_up;
  } cmoc_events_t;

endpackage

// [design/cmoc_wave_chan.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cmoc_consts.svh"

module cmoc_wave_chan #(
  parameter bit TOGGLE_IN_PWM   = 1'b1,
  parameter bit SPECIAL_AT_TOP  = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire cmoc_pkg::cmoc_class_t mode_class,
  input  wire logic [1:0]            com,
  input  wire logic                  mode_hi,
  input  wire cmoc_pkg::cmoc_events_t ev,
  input  wire logic                  match,
  input  wire logic                  force_cmp,
  input  wire logic                  cmp_is_top,
  output logic                       wave
);

  logic next_wave;   // Next waveform level
  logic match_t;     // Match qualified by tick
  logic special;     // Compare at top with high field bit
  logic top_t;       // Tick at top
  logic bot_t;       // Tick at bottom

  // Next waveform level
  always_comb begin
    match_t   = match & ev.tick;
    top_t     = ev.at_top & ev.tick;
    bot_t     = ev.at_bottom & ev.tick;
    special   = com[1] & cmp_is_top;
    next_wave = wave;  // Hold by default, also while disconnected
    case (mode_class)
      cmoc_pkg::CMOC_NON_PWM: begin
        // Match or forced compare
        if (match_t || force_cmp) begin
          case (com)
            `CMOC_COM_TOGGLE: next_wave = ~wave;
            `CMOC_COM_CLEAR:  next_wave = 1'b0;
            `CMOC_COM_SET:    next_wave = 1'b1;
            default:          next_wave = wave;
          endcase
        end
      end
      cmoc_pkg::CMOC_FAST_PWM: begin
        if (com == `CMOC_COM_TOGGLE) begin
          // Toggle only on channel A with hi bit
          if (TOGGLE_IN_PWM && mode_hi && match_t) begin
            next_wave = ~wave;
          end
        end else if (com[1]) begin
          // Match level is the low field bit
          if (match_t && !special) begin
            next_wave = com[0];
          end
          if (bot_t && !(SPECIAL_AT_TOP && special)) begin
            next_wave = ~com[0];
          end
          if (SPECIAL_AT_TOP && special && top_t) begin
            next_wave = ~com[0];
          end
        end
      end
      cmoc_pkg::CMOC_PHASE_PWM: begin
        if (com == `CMOC_COM_TOGGLE) begin
          // Same as fast PWM toggle
          if (TOGGLE_IN_PWM && mode_hi && match_t) begin
            next_wave = ~wave;
          end
        end else if (com[1]) begin
          if (special) begin
            // Match ignored, level applied at top
            if (top_t) begin
              next_wave = ~com[0];
            end
          end else if (match_t) begin
            // Up match to low bit, down match to opposite
            next_wave = ev.count_up ? com[0] : ~com[0];
          end
        end
      end
      default: next_wave = wave;
    endcase
  end

  // Waveform register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

endmodule

`default_nettype wire

// [bench/cmoc_top_props.sv]
`timescale 1ns/100ps
`default_nettype none

module cmoc_top_props (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic [7:0] BUS_ADDR,
  input wire logic       BUS_IO_SPACE,
  input wire logic       BUS_WRITE,
  input wire logic       BUS_READ,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  input wire logic       TICK_EN,
  input wire logic [7:0] CHAN_A_COMPARE_VALUE,
  input wire logic       MATCH_A,
  input wire logic       AT_BOTTOM,
  input wire logic       COUNT_UP,
  input wire logic       WAVEFORM_MODE_HI_BIT,
  input wire logic       FORCE_A,
  input wire logic       DIR_A,
  input wire logic       PORT_A,
  input wire logic [2:0] WAVEFORM_MODE_SEL,
  input wire logic       CHAN_A_WAVE_OUT,
  input wire logic       CHAN_A_CONNECTED,
  input wire logic       PIN_A_OUT,
  input wire logic       PIN_A_OE
);
  logic       hit;     // Access lands on the control register
  logic [7:0] shadow;  // Copy of the control register

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Either address space reaches the register
  assign hit = (!BUS_IO_SPACE && BUS_ADDR == 8'h44) || (BUS_IO_SPACE && BUS_ADDR == 8'h24);

  // Tracks writable bits of the register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shadow <= 8'h00;
    end else if (BUS_WRITE && hit) begin
      shadow <= BUS_WDATA & 8'hF3;
    end
  end

  a_read_mapped: assert property (BUS_READ && hit |=> BUS_RDATA == $past(shadow))
    else $error("register read wrong");
  a_read_unmapped: assert property (BUS_READ && !hit |=> BUS_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_conn_a_lag: assert property (BUS_WRITE && hit |-> ##2
    CHAN_A_CONNECTED == ($past(BUS_WDATA[7:6], 2) != 2'h0)) else $error("connect A wrong");
  a_mode_sel: assert property (WAVEFORM_MODE_SEL == {WAVEFORM_MODE_HI_BIT, shadow[1:0]})
    else $error("mode select wrong");
  a_oe_dir: assert property (1'b1 |=> PIN_A_OE == $past(DIR_A))
    else $error("driver enable wrong");
  a_no_tick_hold: assert property (!TICK_EN && !FORCE_A |=> $stable(CHAN_A_WAVE_OUT))
    else $error("wave moved without tick");
  a_nonpwm_act: assert property ((FORCE_A || TICK_EN && MATCH_A) && !WAVEFORM_MODE_SEL[0]
    && !WAVEFORM_MODE_SEL[2] && shadow[7] |=> CHAN_A_WAVE_OUT == $past(shadow[6]))
    else $error("non-PWM action wrong");
  a_fast_bottom: assert property (TICK_EN && AT_BOTTOM && WAVEFORM_MODE_SEL[1:0] == 2'h3
    && shadow[7] |=> CHAN_A_WAVE_OUT != $past(shadow[6])) else $error("bottom action wrong");
  a_phase_match: assert property (TICK_EN && MATCH_A && WAVEFORM_MODE_SEL == 3'h1
    && shadow[7] && CHAN_A_COMPARE_VALUE != 8'hFF
    |=> CHAN_A_WAVE_OUT == ($past(COUNT_UP) ~^ $past(shadow[6]))) else $error("phase wrong");
  a_pin_a_out: assert property (!BUS_WRITE && !$past(BUS_WRITE) |=> PIN_A_OUT ==
    ($past(CHAN_A_CONNECTED) ? $past(CHAN_A_WAVE_OUT) : $past(PORT_A)))
    else $error("pin level wrong");
endmodule

bind cmoc_top cmoc_top_props cmoc_top_props_inst (.*);

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic       CLK = 1'b0;
  logic       RESET_N, BUS_IO_SPACE, BUS_WRITE, BUS_READ, TICK_EN, MATCH_A, MATCH_B, AT_TOP;
  logic       AT_BOTTOM, COUNT_UP, WAVEFORM_MODE_HI_BIT, FORCE_A, FORCE_B, DIR_A, DIR_B;
  logic       PORT_A, PORT_B, CHAN_A_WAVE_OUT, CHAN_B_WAVE_OUT, CHAN_A_CONNECTED;
  logic       CHAN_B_CONNECTED, PIN_A_OUT, PIN_A_OE, PIN_B_OUT, PIN_B_OE;
  logic [7:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, CHAN_A_COMPARE_VALUE, CHAN_B_COMPARE_VALUE;
  logic [2:0] WAVEFORM_MODE_SEL;
  logic [7:0] ctrl_m, rd_m, seg_ca, seg_cb;  // Expected register, read data, compares
  logic       wa_m, wb_m, ca_m, cb_m, pa_m, pb_m, oa_m, ob_m, seg_hi;  // Expected outputs
  int         fails, checks;
  logic [31:0] r;

  cmoc_top cmoc_top_inst (.*);

  // 125 MHz clock
  always #4 CLK = ~CLK;

  // Next waveform level of one channel
  function automatic logic nxt(logic w, logic [2:0] m, logic [1:0] c, logic isb, logic t,
                               logic mt, logic tp, logic bt, logic up, logic f,
                               logic [7:0] cmp, logic [7:0] ca);
    logic [7:0] top;
    logic       sp;
    top = (m == 3'h5 || m == 3'h7) ? ca : 8'hFF;
    sp  = c[1] && cmp == top;
    nxt = w;
    if (m == 3'h0 || m == 3'h2) begin
      if (f || (t && mt)) nxt = (c == 2'h1) ? !w : (c[1] ? c[0] : w);
    end else if (t && (m == 3'h3 || m == 3'h7)) begin
      if (bt && c[1] && !(isb && sp)) nxt = !c[0];
      else if (isb && sp && tp) nxt = !c[0];
      else if (mt && !sp) nxt = c[1] ? c[0] : ((c == 2'h1 && !isb && m[2]) ? !w : w);
    end else if (t && (m == 3'h1 || m == 3'h5)) begin
      if (sp) nxt = tp ? !c[0] : w;
      else if (mt) nxt = c[1] ? (up ~^ c[0]) : ((c == 2'h1 && !isb && m[2]) ? !w : w);
    end
  endfunction

  // Compares one value and counts it
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One clock: update expectations, drive new inputs, compare
  task automatic step(input logic wr, input logic rd, input logic [7:0] ad, input logic io,
                      input logic [7:0] wd);
    logic t;
    logic hit;
    @(posedge CLK);
    hit = (!BUS_IO_SPACE && BUS_ADDR == 8'h44) || (BUS_IO_SPACE && BUS_ADDR == 8'h24);
    if (BUS_READ) rd_m = hit ? ctrl_m : 8'h00;
    ca_m = |ctrl_m[7:6];
    cb_m = |ctrl_m[5:4];
    pa_m = ca_m ? wa_m : PORT_A;
    pb_m = cb_m ? wb_m : PORT_B;
    oa_m = DIR_A;
    ob_m = DIR_B;
    wa_m = nxt(wa_m, {WAVEFORM_MODE_HI_BIT, ctrl_m[1:0]}, ctrl_m[7:6], 1'b0, TICK_EN, MATCH_A,
               AT_TOP, AT_BOTTOM, COUNT_UP, FORCE_A, CHAN_A_COMPARE_VALUE, CHAN_A_COMPARE_VALUE);
    wb_m = nxt(wb_m, {WAVEFORM_MODE_HI_BIT, ctrl_m[1:0]}, ctrl_m[5:4], 1'b1, TICK_EN, MATCH_B,
               AT_TOP, AT_BOTTOM, COUNT_UP, FORCE_B, CHAN_B_COMPARE_VALUE, CHAN_A_COMPARE_VALUE);
    if (BUS_WRITE && hit) begin
      ctrl_m = BUS_WDATA & 8'hF3;
    end
    t = ($urandom % 4) != 0;
    TICK_EN <= t;
    MATCH_A <= ($urandom % 3) == 0;
    MATCH_B <= ($urandom % 3) == 0;
    r = $urandom;
    AT_TOP <= r[1:0] == 2'h1;
    AT_BOTTOM <= r[1:0] == 2'h2;
    COUNT_UP <= r[2];
    FORCE_A <= !t && r[4:3] == 2'h0;
    FORCE_B <= !t && r[6:5] == 2'h0;
    {DIR_A, DIR_B, PORT_A, PORT_B} <= r[10:7];
    {BUS_WRITE, BUS_READ, BUS_ADDR, BUS_IO_SPACE, BUS_WDATA} <= {wr, rd, ad, io, wd};
    {CHAN_A_COMPARE_VALUE, CHAN_B_COMPARE_VALUE, WAVEFORM_MODE_HI_BIT} <= {seg_ca, seg_cb, seg_hi};
    #1;
    chk("wave_a", {7'h00, wa_m}, {7'h00, CHAN_A_WAVE_OUT});
    chk("wave_b", {7'h00, wb_m}, {7'h00, CHAN_B_WAVE_OUT});
    chk("rdata", rd_m, BUS_RDATA);
    chk("mode_sel", {5'h00, WAVEFORM_MODE_HI_BIT, ctrl_m[1:0]}, 8'(WAVEFORM_MODE_SEL));
    chk("conn", {6'h00, ca_m, cb_m}, {6'h00, CHAN_A_CONNECTED, CHAN_B_CONNECTED});
    chk("pin_oe", {6'h00, oa_m, ob_m}, {6'h00, PIN_A_OE, PIN_B_OE});
    chk("pin_out", {6'h00, pa_m, pb_m}, {6'h00, PIN_A_OUT, PIN_B_OUT});
  endtask

  // Prints counts and verdict, then stops
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {RESET_N, BUS_IO_SPACE, BUS_WRITE, BUS_READ, TICK_EN, MATCH_A, MATCH_B, AT_TOP} = 8'h00;
    {AT_BOTTOM, COUNT_UP, WAVEFORM_MODE_HI_BIT, FORCE_A, FORCE_B, DIR_A, DIR_B} = 7'h00;
    {PORT_A, PORT_B, BUS_ADDR, BUS_WDATA, CHAN_A_COMPARE_VALUE, CHAN_B_COMPARE_VALUE} = 34'h0;
    {ctrl_m, rd_m, seg_ca, seg_cb, wa_m, wb_m, ca_m, cb_m, pa_m, pb_m, oa_m, ob_m, seg_hi} = '0;
    fails  = 0;
    checks = 0;
    r = $urandom(32'h4d93871a);
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    // Register reset value, both spaces, masked bits, unmapped places
    step(0, 1, 8'h44, 0, 8'h00);
    step(1, 0, 8'h24, 1, 8'hFF);
    step(0, 1, 8'h44, 0, 8'h00);
    step(1, 0, 8'h45, 0, 8'h00);
    step(1, 1, 8'h44, 0, 8'h00);
    step(0, 1, 8'h24, 0, 8'h00);
    step(0, 1, 8'h44, 1, 8'h00);
    step(0, 1, 8'h24, 1, 8'h00);
    $display("test registers done");
    // Every mode with every channel A field, random events and compare corners
    for (int m = 0; m < 8; m++) begin
      for (int c = 0; c < 4; c++) begin
        r = $urandom;
        seg_hi = m[2];
        seg_ca = (r[1:0] == 2'h0) ? 8'h00 : (r[1:0] == 2'h1) ? 8'hFF : r[15:8];
        seg_cb = (r[3:2] == 2'h0) ? seg_ca : (r[3:2] == 2'h1) ? 8'hFF : r[23:16];
        step(1, 0, r[24] ? 8'h24 : 8'h44, r[24], {c[1:0], r[5:4], r[7:6], m[1:0]});
        repeat (60) step(0, r[25], 8'h44, 0, 8'h00);
      end
    end
    $display("test waveform done");
    finish_test();
  end
endmodule

`default_nettype wire
